// ===== rtl/hrb_dev_port.sv
// Device end: register port with strap-selected bus personality
`timescale 1ns/1ns
module hrb_dev_port #(
   parameter logic [2:0] CHIP_CODE = hrb_pkg::HRB_CHIP_CODE_DEF
) (
   // Core clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // Link
   hrb_link_if.dev                             lnk,
   // Register core access
   output logic [hrb_pkg::HRB_REG_AW-1:0]      core_addr,
   output logic [hrb_pkg::HRB_DATA_W-1:0]      core_wdata,
   output logic                                core_wr,
   output logic                                core_rd,
   input  wire logic [hrb_pkg::HRB_DATA_W-1:0] core_rdata
);
   import hrb_pkg::*;

   typedef enum {D_IDLE, D_BUSY, D_DONE} hrb_dst_e;

   localparam int PIN_W = HRB_MODE_W + 4 + HRB_ADDR_W + HRB_DATA_W;

   // --------------------------------------------------------------
   // Link domain: pin sampling and reset
   // --------------------------------------------------------------
   logic                  lrst_s1_q, lrst_b_q;
   logic [PIN_W-1:0]      pin_s1_q, pin_s2_q;
   logic [3:0]            ctl_s3_q;
   logic [HRB_MODE_W-1:0] strap_s;
   logic                  cs_n_s, ale_s, strb_n_s, wr_dir_s;
   logic [HRB_ADDR_W-1:0] addr_s;
   logic [HRB_DATA_W-1:0] din_s;

   // Link clock is the port's time base in every personality
   always_ff @(posedge lnk.link_clk) begin
      lrst_s1_q <= rst_b;
      lrst_b_q  <= lrst_s1_q;
      pin_s1_q  <= {lnk.host_mode_strap, lnk.cs_n, lnk.address_latch_strobe,
                    lnk.rd_strobe_n, lnk.wr_or_dir, lnk.addr, lnk.data_bus};
      pin_s2_q  <= pin_s1_q;
      ctl_s3_q  <= pin_s2_q[PIN_W-HRB_MODE_W-1 -: 4];
   end

   assign {strap_s, cs_n_s, ale_s, strb_n_s, wr_dir_s, addr_s, din_s} = pin_s2_q;

   // --------------------------------------------------------------
   // Strap capture
   // --------------------------------------------------------------
   logic [HRB_MODE_W-1:0] mode_q;
   logic                  strap_done_q;

   always_ff @(posedge lnk.link_clk) begin
      if (!lrst_b_q) begin
         mode_q       <= HRB_MODE_LATCHED;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         mode_q       <= strap_s;
         strap_done_q <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Address path
   // --------------------------------------------------------------
   logic [HRB_ADDR_W-1:0] addr_lat_q;
   logic [HRB_ADDR_W-1:0] eff_addr;
   logic                  ale_fall, strb_fall, wr_fall;
   logic                  sel, latched, shared;

   // Falling edge of each pin: latch strobe closes, read strobe or write line goes active low
   assign ale_fall  = ctl_s3_q[2] & ~ale_s;
   assign strb_fall = ctl_s3_q[1] & ~strb_n_s;
   assign wr_fall   = ctl_s3_q[0] & ~wr_dir_s;
   assign latched   = (mode_q == HRB_MODE_LATCHED);
   assign shared    = (mode_q == HRB_MODE_ASYNC_DS) || (mode_q == HRB_MODE_CLOCKED);

   always_ff @(posedge lnk.link_clk) begin
      if (!lrst_b_q) begin
         addr_lat_q <= '0;
      end else if (ale_fall) begin
         addr_lat_q <= addr_s;
      end
   end

   // Strobe high (or tied high) lets the address straight through
   assign eff_addr = ale_s ? addr_s : addr_lat_q;
   assign sel      = !cs_n_s && (eff_addr[HRB_CHIP_MSB:HRB_CHIP_LSB] == CHIP_CODE);

   // --------------------------------------------------------------
   // Cycle decode and sequencing
   // --------------------------------------------------------------
   logic                  start_rd, start_wr, own_strb_n, cyc_end;
   hrb_dst_e              st_q;
   logic                  is_rd_q;
   logic [HRB_REG_AW-1:0] cyc_addr_q;
   logic [HRB_DATA_W-1:0] cyc_wdata_q;
   logic                  req_tgl_q;
   logic                  ack_tgl_q;
   logic                  at_s1_q, at_s2_q, at_s3_q;
   logic [HRB_DATA_W-1:0] rdata_x_q;
   logic [HRB_DATA_W-1:0] dout_q;
   logic                  oe_q;
   logic                  ack_n_q;

   always_comb begin
      start_rd = 1'b0;
      start_wr = 1'b0;
      if (latched) begin
         start_rd = sel && strb_fall;
         start_wr = sel && wr_fall;
      end else if (shared) begin
         start_rd = sel && strb_fall && wr_dir_s;
         start_wr = sel && strb_fall && !wr_dir_s;
      end
   end

   assign own_strb_n = (latched && !is_rd_q) ? wr_dir_s : strb_n_s;
   assign cyc_end    = cs_n_s || own_strb_n;

   always_ff @(posedge lnk.link_clk) begin
      at_s1_q <= ack_tgl_q;
      at_s2_q <= at_s1_q;
      at_s3_q <= at_s2_q;
   end

   always_ff @(posedge lnk.link_clk) begin
      if (!lrst_b_q) begin
         st_q        <= D_IDLE;
         is_rd_q     <= 1'b0;
         cyc_addr_q  <= '0;
         cyc_wdata_q <= HRB_DATA_RST;
         req_tgl_q   <= 1'b0;
         dout_q      <= HRB_DATA_RST;
         ack_n_q     <= 1'b1;
      end else begin
         case (st_q)
            D_IDLE: begin
               if (start_rd || start_wr) begin
                  is_rd_q     <= start_rd;
                  cyc_addr_q  <= eff_addr[HRB_REG_AW-1:0];
                  cyc_wdata_q <= din_s;
                  req_tgl_q   <= ~req_tgl_q;
                  st_q        <= D_BUSY;
               end
            end
            D_BUSY: begin
               if (at_s2_q != at_s3_q) begin
                  if (is_rd_q) begin
                     dout_q <= rdata_x_q;
                  end
                  ack_n_q <= 1'b0;
                  st_q    <= D_DONE;
               end
            end
            default: begin
               if (cyc_end) begin
                  ack_n_q <= 1'b1;
                  st_q    <= D_IDLE;
               end
            end
         endcase
      end
   end

   // Drivers on only for a selected read; no output enable pin exists
   always_ff @(posedge lnk.link_clk) begin
      if (!lrst_b_q) begin
         oe_q <= 1'b0;
      end else if (st_q == D_IDLE) begin
         oe_q <= start_rd;
      end else if (cs_n_s || (is_rd_q && strb_n_s)) begin
         oe_q <= 1'b0;
      end
   end

   assign lnk.data_dev_o       = dout_q;
   assign lnk.data_dev_oe      = oe_q;
   assign lnk.cycle_done_ack_n = ack_n_q;

   // --------------------------------------------------------------
   // Core domain: toggle handshake with held words
   // --------------------------------------------------------------
   logic rq_s1_q, rq_s2_q, rq_s3_q;
   logic new_req;

   // Link words stay frozen from toggle until ack, so sampling is safe
   assign new_req = rq_s2_q ^ rq_s3_q;

   always_ff @(posedge clk) begin
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_addr  <= '0;
         core_wdata <= HRB_DATA_RST;
         core_wr    <= 1'b0;
         core_rd    <= 1'b0;
         rdata_x_q  <= HRB_DATA_RST;
         ack_tgl_q  <= 1'b0;
      end else begin
         core_wr <= new_req && !is_rd_q;
         core_rd <= new_req && is_rd_q;
         if (new_req) begin
            core_addr  <= cyc_addr_q;
            core_wdata <= cyc_wdata_q;
         end
         if (core_rd) begin
            rdata_x_q <= core_rdata;
         end
         if (core_rd || core_wr) begin
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end
endmodule

// ===== rtl/hrb_pkg.sv
// Shared constants for the host register bus port and its host end
package hrb_pkg;
   // --------------------------------------------------------------
   // Bus personalities selected by the strap
   // --------------------------------------------------------------
   localparam logic [2:0] HRB_MODE_LATCHED = 3'h0;
   localparam logic [2:0] HRB_MODE_ASYNC_DS = 3'h1;
   localparam logic [2:0] HRB_MODE_CLOCKED = 3'h7;

   // --------------------------------------------------------------
   // Widths and field positions
   // --------------------------------------------------------------
   localparam int HRB_ADDR_W   = 11;
   localparam int HRB_DATA_W   = 8;
   localparam int HRB_REG_AW   = 8;
   localparam int HRB_CHIP_MSB = 10;
   localparam int HRB_CHIP_LSB = 8;
   localparam int HRB_MODE_W   = 3;

   // --------------------------------------------------------------
   // Reset and idle values
   // --------------------------------------------------------------
   localparam logic [2:0] HRB_CHIP_CODE_DEF = 3'h0;
   localparam logic [7:0] HRB_BUS_IDLE      = 8'hff;
   localparam logic [7:0] HRB_DATA_RST      = 8'h00;

   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int HRB_CLK_PERIOD_NS   = 50;
   localparam int HRB_T_CS_STROBE_NS  = 65;
   localparam int HRB_T_STROBE_MIN_NS = 90;
   localparam int HRB_CS_STROBE_CYC   =
      (HRB_T_CS_STROBE_NS + HRB_CLK_PERIOD_NS - 1) / HRB_CLK_PERIOD_NS;
   localparam int HRB_STROBE_MIN_CYC  =
      (HRB_T_STROBE_MIN_NS + HRB_CLK_PERIOD_NS - 1) / HRB_CLK_PERIOD_NS;
   // Link clock half period, in clk cycles
   localparam int HRB_LINK_HALF_CYC   = 2;
   // Each pin phase must survive the device's three-stage pin sampling
   localparam int HRB_LINK_SEEN_CYC   = 3 * 2 * HRB_LINK_HALF_CYC;
   localparam int HRB_PHASE_CYC       =
      (HRB_LINK_SEEN_CYC > HRB_STROBE_MIN_CYC) ? HRB_LINK_SEEN_CYC : HRB_STROBE_MIN_CYC;
   localparam int HRB_WAIT_W          = 8;
endpackage

// ===== rtl/hrb_link_if.sv
// Pin-level link between the host end and the register port
`timescale 1ns/1ns
interface hrb_link_if;
   import hrb_pkg::*;
   logic                  link_clk;
   logic [HRB_MODE_W-1:0] host_mode_strap;
   logic [HRB_ADDR_W-1:0] addr;
   logic                  cs_n;
   logic                  address_latch_strobe;
   logic                  rd_strobe_n;
   logic                  wr_or_dir;
   logic                  cycle_done_ack_n;
   logic [HRB_DATA_W-1:0] data_host_o;
   logic                  data_host_oe;
   logic [HRB_DATA_W-1:0] data_dev_o;
   logic                  data_dev_oe;
   logic [HRB_DATA_W-1:0] data_bus;

   // Wire level of the shared data bus; pulled high when nobody drives
   assign data_bus = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : HRB_BUS_IDLE);

   modport host (
      output link_clk, host_mode_strap, addr, cs_n, address_latch_strobe,
      output rd_strobe_n, wr_or_dir, data_host_o, data_host_oe,
      input  cycle_done_ack_n, data_bus
   );
   modport dev (
      input  link_clk, host_mode_strap, addr, cs_n, address_latch_strobe,
      input  rd_strobe_n, wr_or_dir, data_bus,
      output cycle_done_ack_n, data_dev_o, data_dev_oe
   );
endinterface

// ===== rtl/hrb_host_end.sv
// Host end: issues register reads and writes on the parallel port
`timescale 1ns/1ns
module hrb_host_end #(
   parameter logic [2:0] HOST_MODE = hrb_pkg::HRB_MODE_LATCHED,
   parameter logic [2:0] CHIP_CODE = hrb_pkg::HRB_CHIP_CODE_DEF,
   parameter bit         ALE_TIED  = 1'b0
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // Link
   hrb_link_if.host                            lnk,
   // Command
   input  wire logic                           cmd_valid,
   output logic                                cmd_ready,
   input  wire logic                           cmd_write,
   input  wire logic [hrb_pkg::HRB_ADDR_W-1:0] cmd_addr,
   input  wire logic [hrb_pkg::HRB_DATA_W-1:0] cmd_wdata,
   // Response
   output logic                                rsp_valid,
   output logic [hrb_pkg::HRB_DATA_W-1:0]      rsp_rdata
);
   import hrb_pkg::*;

   typedef enum {H_IDLE, H_SETUP, H_ALE_HI, H_ALE_LO, H_STROBE, H_RELEASE, H_GAP} hrb_hst_e;

   hrb_hst_e              st_q;
   logic [HRB_WAIT_W-1:0] wait_q;
   logic                  lclk_q;
   logic [HRB_WAIT_W-1:0] div_q;
   logic                  ack_s1_q, ack_s2_q;
   logic [HRB_DATA_W-1:0] din_s1_q, din_s2_q;
   logic                  cs_n_q, ale_q, strb_n_q, wr_dir_q, wr_q;
   logic [HRB_ADDR_W-1:0] addr_q;
   logic [HRB_DATA_W-1:0] dout_q;
   logic                  doe_q;
   logic                  waited;
   logic                  ale_idle;
   logic                  latched;

   assign waited    = (wait_q == '0);
   assign ale_idle  = ALE_TIED;
   assign latched   = (HOST_MODE == HRB_MODE_LATCHED);
   assign cmd_ready = (st_q == H_IDLE);

   // --------------------------------------------------------------
   // Link clock divider
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // Keeps toggling in reset so the port's link-side reset takes hold
         div_q <= '0;
         if (lclk_q == 1'b1) begin
            lclk_q <= 1'b0;
         end else begin
            lclk_q <= 1'b1;
         end
      end else if (div_q == HRB_WAIT_W'(HRB_LINK_HALF_CYC - 1)) begin
         div_q  <= '0;
         lclk_q <= ~lclk_q;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Pin sampling
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      ack_s1_q <= lnk.cycle_done_ack_n;
      ack_s2_q <= ack_s1_q;
      din_s1_q <= lnk.data_bus;
      din_s2_q <= din_s1_q;
   end

   // --------------------------------------------------------------
   // Cycle sequencer
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q      <= H_IDLE;
         wait_q    <= '0;
         cs_n_q    <= 1'b1;
         ale_q     <= 1'b0;
         strb_n_q  <= 1'b1;
         wr_dir_q  <= 1'b1;
         wr_q      <= 1'b0;
         addr_q    <= '0;
         dout_q    <= HRB_DATA_RST;
         doe_q     <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= HRB_DATA_RST;
      end else begin
         rsp_valid <= 1'b0;
         if (!waited) begin
            wait_q <= wait_q - 1'b1;
         end
         case (st_q)
            H_IDLE: begin
               ale_q <= ale_idle;
               if (cmd_valid) begin
                  addr_q <= cmd_addr;
                  wr_q   <= cmd_write;
                  dout_q <= cmd_wdata;
                  if (cmd_addr[HRB_CHIP_MSB:HRB_CHIP_LSB] == CHIP_CODE) begin
                     cs_n_q <= 1'b0;
                     wait_q <= HRB_WAIT_W'(HRB_PHASE_CYC);
                     st_q   <= H_SETUP;
                  end else begin
                     // Nobody answers a foreign code: read back idle bus
                     rsp_valid <= 1'b1;
                     rsp_rdata <= HRB_BUS_IDLE;
                  end
               end
            end
            H_SETUP: begin
               if (waited) begin
                  ale_q  <= 1'b1;
                  wait_q <= HRB_WAIT_W'(HRB_PHASE_CYC);
                  st_q   <= H_ALE_HI;
               end
            end
            H_ALE_HI: begin
               if (waited) begin
                  ale_q  <= ale_idle;
                  wait_q <= HRB_WAIT_W'(HRB_PHASE_CYC);
                  st_q   <= H_ALE_LO;
                  if (!latched) begin
                     wr_dir_q <= ~wr_q;
                  end
                  doe_q <= wr_q;
               end
            end
            H_ALE_LO: begin
               if (waited) begin
                  if (latched && wr_q) begin
                     wr_dir_q <= 1'b0;
                  end else begin
                     strb_n_q <= 1'b0;
                  end
                  wait_q <= HRB_WAIT_W'(HRB_PHASE_CYC);
                  st_q   <= H_STROBE;
               end
            end
            H_STROBE: begin
               if (waited && !ack_s2_q) begin
                  // End the strobe only after ready is seen and data taken
                  rsp_valid <= 1'b1;
                  rsp_rdata <= wr_q ? dout_q : din_s2_q;
                  strb_n_q  <= 1'b1;
                  if (latched) begin
                     wr_dir_q <= 1'b1;
                  end
                  st_q <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               if (ack_s2_q) begin
                  cs_n_q <= 1'b1;
                  doe_q  <= 1'b0;
                  wait_q <= HRB_WAIT_W'(HRB_PHASE_CYC);
                  st_q   <= H_GAP;
               end
            end
            default: begin
               if (waited) begin
                  wr_dir_q <= 1'b1;
                  st_q     <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign lnk.link_clk             = lclk_q;
   assign lnk.host_mode_strap      = HOST_MODE;
   assign lnk.addr                 = addr_q;
   assign lnk.cs_n                 = cs_n_q;
   assign lnk.address_latch_strobe = ale_q;
   assign lnk.rd_strobe_n          = strb_n_q;
   assign lnk.wr_or_dir            = wr_dir_q;
   assign lnk.data_host_o          = dout_q;
   assign lnk.data_host_oe         = doe_q;
endmodule

// ===== bench/hrb_port_assertions.sv
// Concurrent checks on the pins between the host end and the register port
`timescale 1ns/1ns
module hrb_port_assertions #(
   parameter logic [2:0] CHIP_CODE = hrb_pkg::HRB_CHIP_CODE_DEF
) (
   // Clock and reset
   input wire logic                           clk,
   input wire logic                           rst_b,
   // Link pins
   input wire logic [hrb_pkg::HRB_MODE_W-1:0] host_mode_strap,
   input wire logic [hrb_pkg::HRB_ADDR_W-1:0] addr,
   input wire logic                           cs_n,
   input wire logic                           address_latch_strobe,
   input wire logic                           rd_strobe_n,
   input wire logic                           wr_or_dir,
   input wire logic                           cycle_done_ack_n,
   input wire logic                           data_dev_oe
);
   import hrb_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // Properties, written for the latched personality
   // ------------------------------------------------------------
   property p_strap;
      $stable(host_mode_strap);
   endproperty
   property p_ack_bound;
      ($fell(rd_strobe_n) || $fell(wr_or_dir)) && !cs_n
         && addr[HRB_CHIP_MSB:HRB_CHIP_LSB] == CHIP_CODE
         |-> ##[1:40] !cycle_done_ack_n;
   endproperty
   property p_ack_cause;
      $fell(cycle_done_ack_n) |-> !cs_n && (!rd_strobe_n || !wr_or_dir);
   endproperty
   property p_ack_data;
      $fell(cycle_done_ack_n) && !rd_strobe_n |-> data_dev_oe;
   endproperty
   property p_ack_release;
      $rose(rd_strobe_n) || $rose(wr_or_dir) |-> ##[1:40] cycle_done_ack_n;
   endproperty
   property p_oe_start;
      $rose(data_dev_oe) |-> !cs_n && !rd_strobe_n;
   endproperty
   // Device never drives while a write strobe is low
   property p_oe_read_only;
      data_dev_oe |-> wr_or_dir;
   endproperty
   property p_idle_ack;
      cs_n [*8] |-> cycle_done_ack_n;
   endproperty
   property p_ale_in_cycle;
      address_latch_strobe |-> !cs_n;
   endproperty
   property p_strobe_after_ack;
      $rose(rd_strobe_n) |-> !$past(cycle_done_ack_n);
   endproperty

   a_strap: assert property (p_strap) else $error("strap moved");
   a_ack_bound: assert property (p_ack_bound) else $error("no acknowledge");
   a_ack_cause: assert property (p_ack_cause) else $error("stray acknowledge");
   a_ack_data: assert property (p_ack_data) else $error("ack without data");
   a_ack_release: assert property (p_ack_release) else $error("ack held");
   a_oe_start: assert property (p_oe_start) else $error("drive without read");
   a_oe_read_only: assert property (p_oe_read_only) else $error("drive in write");
   a_idle_ack: assert property (p_idle_ack) else $error("ack unselected");
   a_ale_in_cycle: assert property (p_ale_in_cycle) else $error("latch unselected");
   a_strobe_after_ack: assert property (p_strobe_after_ack) else $error("early end");

   c_write: cover property ($fell(wr_or_dir) && !cs_n);
   c_read_ack: cover property ($fell(cycle_done_ack_n) && !rd_strobe_n);
   c_drive: cover property ($rose(data_dev_oe));
endmodule

// ===== bench/host_register_bus_port_tb.sv
// Self-checking bench: host end against register port in all three modes
`timescale 1ns/1ns
module host_register_bus_port_tb;
   import hrb_pkg::*;
   localparam logic [2:0] MODES [4] = '{HRB_MODE_LATCHED, HRB_MODE_ASYNC_DS, HRB_MODE_CLOCKED,
                                        HRB_MODE_LATCHED};
   logic                  clk         = 1'b0;
   logic                  rst_b       = 1'b0;
   logic [3:0]            cmd_valid   = '0;
   logic [3:0]            cmd_write   = '0;
   logic [HRB_ADDR_W-1:0] cmd_addr  [4] = '{default: '0};
   logic [HRB_DATA_W-1:0] cmd_wdata [4] = '{default: '0};
   wire  [3:0]            cmd_ready;
   wire  [3:0]            rsp_valid;
   wire  [3:0]            core_wr;
   wire  [3:0]            core_rd;
   wire  [HRB_DATA_W-1:0] rsp_rdata [4];
   wire  [HRB_REG_AW-1:0] core_addr [4];
   wire  [HRB_DATA_W-1:0] core_wdata [4];
   wire  [HRB_DATA_W-1:0] core_rdata [4];
   logic [HRB_DATA_W-1:0] regs [4][256];
   int                    n_rd [4]    = '{default: 0};
   logic                  cs_low_seen = 1'b0;
   int                    n_mismatch  = 0;
   int                    cmp_count   = 0;
   int                    cyc         = 0;

   always #25 clk = ~clk;

   // ------------------------------------------------------------
   // Four host/device pairs, one per entry of MODES (latched twice), each with its registers
   // ------------------------------------------------------------
   for (genvar k = 0; k < 4; k++) begin : g
      hrb_link_if hrb_link_if_inst ();
      // Last pair ties the latch strobe high and runs on the live address
      hrb_host_end #(.HOST_MODE(MODES[k]), .ALE_TIED(k == 3)) hrb_host_end_inst (
         .clk(clk), .rst_b(rst_b), .lnk(hrb_link_if_inst),
         .cmd_valid(cmd_valid[k]), .cmd_ready(cmd_ready[k]), .cmd_write(cmd_write[k]),
         .cmd_addr(cmd_addr[k]), .cmd_wdata(cmd_wdata[k]),
         .rsp_valid(rsp_valid[k]), .rsp_rdata(rsp_rdata[k]));
      hrb_dev_port hrb_dev_port_inst (
         .clk(clk), .rst_b(rst_b), .lnk(hrb_link_if_inst),
         .core_addr(core_addr[k]), .core_wdata(core_wdata[k]), .core_wr(core_wr[k]),
         .core_rd(core_rd[k]), .core_rdata(core_rdata[k]));
      // Combinational read, as the core side expects
      assign core_rdata[k] = regs[k][core_addr[k]];
      always @(posedge clk) if (core_wr[k]) regs[k][core_addr[k]] <= core_wdata[k];
      always @(posedge clk) if (core_rd[k]) n_rd[k] <= n_rd[k] + 1;
   end

   hrb_port_assertions hrb_port_assertions_inst (
      .clk(clk), .rst_b(rst_b), .host_mode_strap(g[0].hrb_link_if_inst.host_mode_strap),
      .addr(g[0].hrb_link_if_inst.addr), .cs_n(g[0].hrb_link_if_inst.cs_n),
      .address_latch_strobe(g[0].hrb_link_if_inst.address_latch_strobe),
      .rd_strobe_n(g[0].hrb_link_if_inst.rd_strobe_n),
      .wr_or_dir(g[0].hrb_link_if_inst.wr_or_dir),
      .cycle_done_ack_n(g[0].hrb_link_if_inst.cycle_done_ack_n),
      .data_dev_oe(g[0].hrb_link_if_inst.data_dev_oe));

   always @(posedge clk) if (g[0].hrb_link_if_inst.cs_n === 1'b0) cs_low_seen <= 1'b1;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   // Ready is combinational from idle, so it is stable across the taking edge
   task automatic xfer(input int k, input logic wr, input logic [HRB_ADDR_W-1:0] a,
                       input logic [HRB_DATA_W-1:0] d, output logic [HRB_DATA_W-1:0] q);
      int n;
      n = 0;
      @(negedge clk);
      while (cmd_ready[k] !== 1'b1) @(negedge clk);
      cmd_valid[k] = 1'b1;
      cmd_write[k] = wr;
      cmd_addr[k] = a;
      cmd_wdata[k] = d;
      @(negedge clk);
      cmd_valid[k] = 1'b0;
      while (rsp_valid[k] !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(n < 400, "no response");
      q = rsp_rdata[k];
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Runs first, while the select line is known idle
   task automatic t_foreign();
      logic [7:0] q;
      regs[0][8'h21] = 8'h44;
      cs_low_seen = 1'b0;
      xfer(0, 1'b1, {3'h5, 8'h21}, 8'h99, q);
      chk(regs[0][8'h21] === 8'h44, "foreign write landed");
      xfer(0, 1'b0, {3'h5, 8'h21}, 8'h00, q);
      chk(q === 8'hff, "foreign read data");
      chk(cs_low_seen === 1'b0, "select driven for foreign code");
      chk(g[0].hrb_link_if_inst.data_bus === HRB_BUS_IDLE, "bus driven");
   endtask

   // Back-to-back writes to both address extremes, read back in reverse
   task automatic t_access(input int k);
      logic [7:0] q;
      logic [7:0] a;
      int         r0;
      r0 = n_rd[k];
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 8'h00 : ((i == 1) ? 8'h5a : 8'hff);
         xfer(k, 1'b1, {HRB_CHIP_CODE_DEF, a}, a ^ 8'h3c, q);
         chk(regs[k][a] === (a ^ 8'h3c), "write lost");
      end
      chk(n_rd[k] == r0, "read pulse on write");
      for (int i = 2; i >= 0; i--) begin
         a = (i == 0) ? 8'h00 : ((i == 1) ? 8'h5a : 8'hff);
         xfer(k, 1'b0, {HRB_CHIP_CODE_DEF, a}, 8'h00, q);
         chk(q === (a ^ 8'h3c), "read data");
      end
      chk(n_rd[k] == r0 + 3, "read pulse count");
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial begin
      for (int k = 0; k < 4; k++) for (int i = 0; i < 256; i++) regs[k][i] = '0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (10) @(negedge clk);
      t_foreign();
      for (int k = 0; k < 4; k++) t_access(k);
      chk(g[0].hrb_link_if_inst.data_bus === HRB_BUS_IDLE, "bus not released");
      end_sim();
   end
endmodule
